/* File: common/spu_pkg.sv */
// package for the stack pointer unit: offsets, reset values, event codes
//
// Operation
// RL1: stack grows downward; every push lowers the pointer.
// RL2: pointer always designates the current top of stack in data sram.
// RL3: a single byte push lowers the pointer by exactly one.
// RL4: call or interrupt entry saves return address, lowering pointer by two.
// RL5: a single byte pop raises the pointer by exactly one.
// RL6: subroutine or interrupt return raises the pointer by exactly two.
// RL7: pointer is two 8-bit i/o registers, high and low, rw, reset to zero.
// RL8: software loads pointer above the lowest permitted stack location first.
// RL9: software sets up the stack before any call or interrupt enable.
// RL10: software masks unused upper bits of a saved program counter.
// RL11: push writes at pointer then decrements; pop increments then reads.
package spu_pkg;

    // ----------------------------------------------------------------
    // i/o register offsets and reset values
    // ----------------------------------------------------------------
    localparam logic [5:0]  SPU_OFS_LOW  = 6'h3d;  // arbitrary choice of slot
    localparam logic [5:0]  SPU_OFS_HIGH = 6'h3e;  // arbitrary choice of slot
    localparam logic [7:0]  SPU_RST_BYTE = 8'h00;
    localparam logic [15:0] SPU_RST_PTR  = 16'h0000;
    localparam logic [15:0] SPU_STEP_ONE = 16'h0001;
    localparam logic [15:0] SPU_STEP_TWO = 16'h0002;

    // ----------------------------------------------------------------
    // stack events from instruction execution
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SPU_EV_NONE = 3'h0,
        SPU_EV_PUSH = 3'h1,
        SPU_EV_POP  = 3'h2,
        SPU_EV_CALL = 3'h3,
        SPU_EV_RET  = 3'h4
    } spu_event_t;

    // i/o register access bundle
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } spu_io_req_t;

endpackage

/* File: src/spu_stack_pointer.sv */
// stack pointer unit: two i/o byte registers plus push/pop/call/return update
`timescale 1ns/1ps
module spu_stack_pointer
    import spu_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    input  wire spu_io_req_t io_req_i,
    input  wire spu_event_t  stack_event_i,
    output logic [7:0]       io_rdata_o,
    output logic [15:0]      stack_addr_o,
    output logic [15:0]      stack_ptr_o
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_q;

    // reset asserts at once and releases after two edges
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // pointer update
    // ----------------------------------------------------------------
    logic [15:0] sp_q;
    logic [15:0] sp_d;
    logic [15:0] addr_q;
    logic [15:0] addr_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;

    // an io write replaces only its own byte of the event's new pointer; the other byte
    // and the sram address keep the event's result, so neither side's intent is lost
    always_comb begin
        sp_d   = sp_q;
        addr_d = addr_q;
        unique case (stack_event_i)
            SPU_EV_PUSH: begin
                addr_d = sp_q;                   // write at sp first [RL11]
                sp_d   = sp_q - SPU_STEP_ONE;    // [RL1] [RL3]
            end
            SPU_EV_CALL: begin
                addr_d = sp_q;
                sp_d   = sp_q - SPU_STEP_TWO;    // [RL1] [RL4]
            end
            SPU_EV_POP: begin
                sp_d   = sp_q + SPU_STEP_ONE;    // [RL5]
                addr_d = sp_d;                   // read after increment [RL11]
            end
            SPU_EV_RET: begin
                sp_d   = sp_q + SPU_STEP_TWO;    // [RL6]
                addr_d = sp_q + SPU_STEP_ONE;    // first byte of return address
            end
            default: begin
                sp_d   = sp_q;
                addr_d = addr_q;
            end
        endcase
        if (io_req_i.wr && io_req_i.addr == SPU_OFS_LOW) begin
            sp_d[7:0] = io_req_i.wdata;          // [RL7]
        end
        if (io_req_i.wr && io_req_i.addr == SPU_OFS_HIGH) begin
            sp_d[15:8] = io_req_i.wdata;         // [RL7]
        end
    end

    // pointer register always holds the top of stack [RL2]
    always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            sp_q   <= SPU_RST_PTR;               // [RL7]
            addr_q <= SPU_RST_PTR;
        end else begin
            sp_q   <= sp_d;
            addr_q <= addr_d;
        end
    end

    // ----------------------------------------------------------------
    // i/o read path
    // ----------------------------------------------------------------
    // unmapped offsets read zero so other slaves can be or-ed in
    always_comb begin
        rdata_d = SPU_RST_BYTE;
        if (io_req_i.rd && io_req_i.addr == SPU_OFS_LOW) begin
            rdata_d = sp_q[7:0];                 // [RL7]
        end else if (io_req_i.rd && io_req_i.addr == SPU_OFS_HIGH) begin
            rdata_d = sp_q[15:8];                // [RL7]
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rdata_q <= SPU_RST_BYTE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign io_rdata_o   = rdata_q;
    assign stack_addr_o = addr_q;
    assign stack_ptr_o  = sp_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic        no_io_wr;
    logic        no_io_rd;
    logic [15:0] sp_dec_one;

    // qualifiers for the checks; an i/o write may override any stack event
    assign no_io_wr   = !(io_req_i.wr &&
                          (io_req_i.addr == SPU_OFS_LOW || io_req_i.addr == SPU_OFS_HIGH));
    assign no_io_rd   = !(io_req_i.rd &&
                          (io_req_i.addr == SPU_OFS_LOW || io_req_i.addr == SPU_OFS_HIGH));
    assign sp_dec_one = sp_q - SPU_STEP_ONE;

    sequence s_push_evt;
        stack_event_i == SPU_EV_PUSH && no_io_wr;
    endsequence

    sequence s_pop_evt;
        stack_event_i == SPU_EV_POP && no_io_wr;
    endsequence

    sequence s_call_evt;
        stack_event_i == SPU_EV_CALL && no_io_wr;
    endsequence

    sequence s_ret_evt;
        stack_event_i == SPU_EV_RET && no_io_wr;
    endsequence

    a_push_dec_one: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL3]
        s_push_evt |=> sp_q == $past(sp_q) - SPU_STEP_ONE)
        else $error("push did not lower pointer by one");

    a_call_dec_two: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL4]
        s_call_evt |=> sp_q == $past(sp_q) - SPU_STEP_TWO)
        else $error("call did not lower pointer by two");

    a_pop_inc_one: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL5]
        s_pop_evt |=> sp_q == $past(sp_q) + SPU_STEP_ONE)
        else $error("pop did not raise pointer by one");

    a_ret_inc_two: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL6]
        s_ret_evt |=> sp_q == $past(sp_q) + SPU_STEP_TWO)
        else $error("return did not raise pointer by two");

    a_push_pop_inv: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL11]
        s_push_evt ##1 s_pop_evt |=> sp_q == $past(sp_q, 2) && stack_addr_o == $past(sp_q, 2))
        else $error("pop did not undo push");

    a_push_addr_old: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL11]
        s_push_evt |=> stack_addr_o == $past(sp_q))
        else $error("push address not old pointer");

    // every byte moved must land where the pointer said, or push and pop drift apart
    a_call_addr_old: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL4]
        s_call_evt |=> stack_addr_o == $past(sp_q))
        else $error("call address not old pointer");

    a_pop_addr_new: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL11]
        s_pop_evt |=> stack_addr_o == $past(sp_q) + SPU_STEP_ONE)
        else $error("pop address not raised pointer");

    a_ret_addr_next: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL6]
        s_ret_evt |=> stack_addr_o == $past(sp_q) + SPU_STEP_ONE)
        else $error("return address slot wrong");

    a_push_lowers: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL1]
        (s_push_evt and sp_q > SPU_STEP_TWO) |=> sp_q < $past(sp_q))
        else $error("push did not lower pointer");

    a_idle_holds: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL2]
        (stack_event_i == SPU_EV_NONE && no_io_wr) |=> $stable(sp_q))
        else $error("pointer moved without cause");

    a_idle_addr_holds: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL2]
        stack_event_i == SPU_EV_NONE |=> $stable(stack_addr_o))
        else $error("sram address moved without event");

    a_low_write: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL7]
        (io_req_i.wr && io_req_i.addr == SPU_OFS_LOW) |=> sp_q[7:0] == $past(io_req_i.wdata))
        else $error("low byte write lost");

    a_high_write: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL7]
        (io_req_i.wr && io_req_i.addr == SPU_OFS_HIGH) |=> sp_q[15:8] == $past(io_req_i.wdata))
        else $error("high byte write lost");

    // a byte write only replaces its own byte; the other keeps the event's result
    a_write_keeps_evt: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL7]
        (io_req_i.wr && io_req_i.addr == SPU_OFS_LOW && stack_event_i == SPU_EV_PUSH) |=>
        sp_q[15:8] == $past(sp_dec_one[15:8]))
        else $error("high byte lost push under low write");

    a_high_read: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL7]
        (io_req_i.rd && io_req_i.addr == SPU_OFS_HIGH) |=> io_rdata_o == $past(sp_q[15:8]))
        else $error("high byte read wrong");

    a_low_read: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL7]
        (io_req_i.rd && io_req_i.addr == SPU_OFS_LOW) |=> io_rdata_o == $past(sp_q[7:0]))
        else $error("low byte read wrong");

    a_read_idle_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_sync_q) // [RL7]
        no_io_rd |=> io_rdata_o == SPU_RST_BYTE)
        else $error("read data not zero when idle");

    // reset is the thing checked here, so this one carries no disable
    a_reset_clears: assert property (@(posedge sys_clk_i) // [RL7]
        !rst_sync_q |-> sp_q == SPU_RST_PTR && stack_addr_o == SPU_RST_PTR &&
                        io_rdata_o == SPU_RST_BYTE)
        else $error("reset did not clear the pointer");

endmodule

/* File: testbench/spu_core_model.sv */
// partner model: core execution side that issues stack events
`timescale 1ns/1ps
module spu_core_model
    import spu_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic [15:0] stack_addr_i,
    output spu_event_t       stack_event_o
);
    // data sram image for return addresses; the tests stay inside the low 512 bytes
    logic [7:0] sram_image [0:511];

    // idle until asked; an event stands for exactly one clock, as the unit expects
    initial stack_event_o = SPU_EV_NONE;
    task automatic issue(input spu_event_t ev);
        @(negedge sys_clk_i);
        stack_event_o = ev;
        @(negedge sys_clk_i);
        stack_event_o = SPU_EV_NONE;
    endtask
    // two events on consecutive clocks, with no idle cycle between them
    task automatic issue_pair(input spu_event_t ev_a, input spu_event_t ev_b);
        @(negedge sys_clk_i);
        stack_event_o = ev_a;
        @(negedge sys_clk_i);
        stack_event_o = ev_b;
        @(negedge sys_clk_i);
        stack_event_o = SPU_EV_NONE;
    endtask
    // after a call: low byte at the old pointer, high byte below it; the top
    // three bits are stored as junk since only thirteen bits are meaningful
    task automatic save_pc(input logic [15:0] pc);
        logic [8:0] slot;
        slot = stack_addr_i[8:0];
        sram_image[slot] = pc[7:0];
        sram_image[slot - 9'h001] = {3'h7, pc[12:8]};
    endtask
    // after a return: the address shows the high byte; software masks the junk
    task automatic load_pc(output logic [15:0] pc);
        logic [8:0] slot;
        slot = stack_addr_i[8:0];
        pc = {sram_image[slot], sram_image[slot + 9'h001]} & 16'h1fff;
    endtask
endmodule

/* File: testbench/spu_stack_pointer_test.sv */
// self-checking bench for the stack pointer unit
`timescale 1ns/1ps
module spu_stack_pointer_test;
    import spu_pkg::*;
    logic        sys_clk_i  = 1'b0;
    logic        nrst_i     = 1'b0;
    spu_io_req_t io_req_i   = '0;
    spu_event_t  stack_event_i;
    logic [7:0]  io_rdata_o;
    logic [15:0] stack_addr_o;
    logic [15:0] stack_ptr_o;
    logic [15:0] saved_pc;
    int          fail_count = 0;
    int          num_checks = 0;

    // 100 mhz clock
    always #5 sys_clk_i = ~sys_clk_i;

    spu_stack_pointer spu_stack_pointer_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .io_req_i(io_req_i), .stack_event_i(stack_event_i), .io_rdata_o(io_rdata_o),
        .stack_addr_o(stack_addr_o), .stack_ptr_o(stack_ptr_o));
    spu_core_model spu_core_model_inst (.sys_clk_i(sys_clk_i), .stack_addr_i(stack_addr_o),
        .stack_event_o(stack_event_i));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // strobes last one cycle; the next call leaves an idle cycle in between
    task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        io_req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk_i);
        io_req_i = '0;
    endtask
    // read data only stands one cycle, so it is taken at the next falling edge
    task automatic io_rd(input logic [5:0] a, input logic [7:0] e);
        @(negedge sys_clk_i);
        io_req_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge sys_clk_i);
        io_req_i = '0;
        check16({8'h00, io_rdata_o}, {8'h00, e}, "read data");
    endtask
    task automatic step(input spu_event_t e, input logic [15:0] sp, input logic [15:0] ad);
        spu_core_model_inst.issue(e);
        check16(stack_ptr_o, sp, "pointer");
        check16(stack_addr_o, ad, "sram address");
    endtask
    task automatic finish_test;
        if (fail_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    // stack is loaded above the lowest legal location before any call
    initial begin
        repeat (2) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        check16(stack_ptr_o, SPU_RST_PTR, "reset pointer");
        io_rd(SPU_OFS_HIGH, SPU_RST_BYTE);
        io_rd(SPU_OFS_LOW, SPU_RST_BYTE);
        io_wr(SPU_OFS_HIGH, 8'h01);
        io_wr(SPU_OFS_LOW, 8'h00);
        check16(stack_ptr_o, 16'h0100, "loaded pointer");
        step(SPU_EV_PUSH, 16'h00ff, 16'h0100);
        io_rd(SPU_OFS_HIGH, 8'h00);
        io_rd(SPU_OFS_LOW, 8'hff);
        step(SPU_EV_POP, 16'h0100, 16'h0100);
        step(SPU_EV_CALL, 16'h00fe, 16'h0100);
        spu_core_model_inst.save_pc(16'h0abc);
        step(SPU_EV_PUSH, 16'h00fd, 16'h00fe);
        step(SPU_EV_POP, 16'h00fe, 16'h00fe);
        step(SPU_EV_RET, 16'h0100, 16'h00ff);
        spu_core_model_inst.load_pc(saved_pc);
        check16(saved_pc, 16'h0abc, "saved return address");
        spu_core_model_inst.issue_pair(SPU_EV_PUSH, SPU_EV_POP);
        check16(stack_ptr_o, 16'h0100, "pointer after push pop");
        check16(stack_addr_o, 16'h0100, "address after push pop");
        // the written byte overrides that byte of the pushed pointer
        fork
            io_wr(SPU_OFS_LOW, 8'h80);
            spu_core_model_inst.issue(SPU_EV_PUSH);
        join
        check16(stack_ptr_o, 16'h0080, "pointer under write");
        check16(stack_addr_o, 16'h0100, "address under write");
        // reset in mid-run clears both bytes at once
        nrst_i = 1'b0;
        @(negedge sys_clk_i);
        check16(stack_ptr_o, SPU_RST_PTR, "pointer after reset");
        check16(stack_addr_o, SPU_RST_PTR, "address after reset");
        nrst_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        io_rd(SPU_OFS_LOW, SPU_RST_BYTE);
        io_rd(6'h00, 8'h00);
        finish_test();
    end

    // tests take about 42 cycles; several times that means a hang
    initial begin
        #4000;
        fail_count++;
        finish_test();
    end
endmodule
